// ===== design/sbl_codec.sv
// Transmit encoder/serializer and receive aligner/decoder of a point-to-point
// byte link. Assumes the core clock is the bit clock and all pins are
// synchronous to it; width and test selects are held static.
`default_nettype none

// Summary of operation
// - Strobed word moves to encoder at boundary
// - Empty byte slot sends the Sync symbol
// - Byte clock fall marks boundary and loading
// - Late strobe never lost, may add Sync
// - Receive byte clock pulses never shorter
// - Aligning Sync and later symbols decode correctly
// - Bypass test: one bit per input clock
// - High test select: plain NRZ output
// - Grounded negative input: crystal clocks bits
// - Nibbles and groups map through fixed tables
// - Ten-bit lower group is bit nine first
// - Most significant bit shifted out first
// - Nonzero command sends its single command symbol
// - Sync is idle-only, decodes as zero
// - Ones are transitions, zeros none, both directions
// - Zero command sends data, else command
// - Width select splits the twelve lines
// - Sync clears commands, pulses command strobe
module sbl_codec
  import sbl_pkg::*;
#(
  parameter int RX_TEST_RUN = SBL_RX_TEST_RUN
) (
  // Clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        ARST_N_I,
  // Static configuration
  input  wire logic [1:0]  WIDTH_SELECT_I,
  input  wire logic [1:0]  TEST_LEVEL_SELECT_I,
  // Transmit host side
  input  wire logic [11:0] TX_LINES_I,
  input  wire logic        INPUT_STROBE_I,
  input  wire logic        TX_REF_CLK_I,
  output logic             ACK_O,
  output logic             INPUT_READY_O,
  // Transmit serial side
  output logic             SERIAL_OUT_O,
  output logic             SERIAL_OUT_N_O,
  output logic             TX_BYTE_CLK_O,
  // Receive serial side
  input  wire logic        SERIAL_IN_POS_I,
  input  wire logic        SERIAL_IN_NEG_I,
  input  wire logic        CRYSTAL_IN_I,
  // Receive host side
  output logic [9:0]       RX_DATA_O,
  output logic [3:0]       RX_CMD_O,
  output logic             DATA_OUT_STROBE_O,
  output logic             COMMAND_OUT_STROBE_O,
  output logic             VIOLATION_O,
  output logic             RX_BYTE_CLK_O,
  output logic             RX_TEST_MODE_O
);

  // ==========================================================================
  // Symbol helpers
  // ==========================================================================
  function automatic logic [3:0] nbits(input logic [1:0] w);
    return (w == SBL_W9) ? SBL_NB9 : (w == SBL_W10) ? SBL_NB10 : SBL_NB8;
  endfunction

  // Split the twelve lines into data and command fields
  function automatic sbl_word_s split(input logic [1:0] w, input logic [11:0] l);
    sbl_word_s s;
    s = {l[11:8], 2'b00, l[7:0]};
    if (w == SBL_W9) s = {1'b0, l[11:9], 1'b0, l[8:0]};
    else if (w == SBL_W10) s = {2'b00, l[11:10], l[9:0]};
    return s;
  endfunction

  // Left-justified symbol; idle selects command table index 0, the Sync symbol
  function automatic logic [11:0] encode(input logic [1:0] w, input sbl_word_s s, input logic idle);
    logic [11:0] sym;
    sym = 12'h000;
    if (w == SBL_W9) begin
      if (idle || s.cmd != 4'h0) sym = {SBL_CMD9[idle ? 3'h0 : s.cmd[2:0]], 1'b0};
      else sym = {SBL_T56[s.data[8:4]], SBL_T45[s.data[3:0]], 1'b0};
    end else if (w == SBL_W10) begin
      if (idle || s.cmd != 4'h0) sym = SBL_CMD10[idle ? 2'h0 : s.cmd[1:0]];
      else sym = {SBL_T56[s.data[8:4]], SBL_T56[{s.data[9], s.data[3:0]}]};
    end else begin
      if (idle || s.cmd != 4'h0) sym = {SBL_CMD8[idle ? 4'h0 : s.cmd], 2'b00};
      else sym = {SBL_T45[s.data[7:4]], SBL_T45[s.data[3:0]], 2'b00};
    end
    return sym;
  endfunction

  // Inverse lookups return a found flag above the value
  function automatic logic [4:0] inv45(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) if (SBL_T45[i] == c) r = {1'b1, 4'(i)};
    return r;
  endfunction

  function automatic logic [5:0] inv56(input logic [5:0] c);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 32; i++) if (SBL_T56[i] == c) r = {1'b1, 5'(i)};
    return r;
  endfunction

  // Decode the newest bits of the history, right-justified
  function automatic sbl_dec_s decode(input logic [1:0] w, input logic [11:0] h);
    sbl_dec_s   d;
    logic [5:0] a;
    logic [5:0] b;
    d = '{kind: SBL_SYM_BAD, val: 10'h000};
    a = 6'h00;
    b = 6'h00;
    if (w == SBL_W9) begin
      a = inv56(h[10:5]);
      b = {1'b0, inv45(h[4:0])};
      if (a[5] && b[4]) d = '{kind: SBL_SYM_DATA, val: {1'b0, a[4:0], b[3:0]}};
      for (int i = 0; i < 8; i++) begin
        if (h[10:0] == SBL_CMD9[i]) d = '{kind: (i == 0) ? SBL_SYM_SYNC : SBL_SYM_CMD, val: 10'(i)};
      end
    end else if (w == SBL_W10) begin
      a = inv56(h[11:6]);
      b = inv56(h[5:0]);
      if (a[5] && b[5]) d = '{kind: SBL_SYM_DATA, val: {b[4], a[4:0], b[3:0]}};
      for (int i = 0; i < 4; i++) begin
        if (h == SBL_CMD10[i]) d = '{kind: (i == 0) ? SBL_SYM_SYNC : SBL_SYM_CMD, val: 10'(i)};
      end
    end else begin
      a = {1'b0, inv45(h[9:5])};
      b = {1'b0, inv45(h[4:0])};
      if (a[4] && b[4]) d = '{kind: SBL_SYM_DATA, val: {2'b00, a[3:0], b[3:0]}};
      for (int i = 0; i < 16; i++) begin
        if (h[9:0] == SBL_CMD8[i]) d = '{kind: (i == 0) ? SBL_SYM_SYNC : SBL_SYM_CMD, val: 10'(i)};
      end
    end
    return d;
  endfunction

  // ==========================================================================
  // Transmit: strobe capture and input buffer
  // ==========================================================================
  logic [3:0]  nb;
  logic        input_strobe_q;
  logic        push;
  logic        buf_valid;
  sbl_word_s   buf_word;
  logic        tx_ref_q;
  logic        tx_bit_en;
  logic [3:0]  tx_cnt;
  logic [3:0]  next_tx_cnt;
  logic        tx_bnd;
  logic [11:0] tx_sh;
  logic [11:0] load_sym;
  logic [11:0] sync_sym;

  assign nb   = nbits(WIDTH_SELECT_I);
  assign push = INPUT_STROBE_I & ~input_strobe_q;  // Rising edge only, one word per strobe

  // A word refused while the buffer is full is lost; pacing is the host's job
  sbl_pair_buf #(
    .WIDTH ($bits(sbl_word_s)),
    .DEPTH (2)
  ) u_in_buf (
    .clk_i     (CORE_CLK_I),
    .rst_n_i   (ARST_N_I),
    .s_valid_i (push),
    .s_data_i  (split(WIDTH_SELECT_I, TX_LINES_I)),
    .s_ready_o (INPUT_READY_O),
    .m_valid_o (buf_valid),
    .m_data_o  (buf_word),
    .m_ready_i (tx_bnd)
  );

  // Acknowledge a captured word one cycle after its strobe edge
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      input_strobe_q <= 1'b0;
      ACK_O  <= 1'b0;
    end else begin
      input_strobe_q <= INPUT_STROBE_I;
      ACK_O  <= push & INPUT_READY_O;
    end
  end

  // ==========================================================================
  // Transmit: bit pacing, shifter and line coding
  // ==========================================================================
  // In bypass each rising edge of the reference input advances one bit
  assign tx_bit_en   = (TEST_LEVEL_SELECT_I == SBL_TLS_BYP) ? (TX_REF_CLK_I & ~tx_ref_q) : 1'b1;
  assign tx_bnd      = tx_bit_en && (tx_cnt == nb - 4'h1);
  assign next_tx_cnt = tx_bnd ? 4'h0 : tx_cnt + 4'h1;
  assign sync_sym    = encode(WIDTH_SELECT_I, buf_word, 1'b1);
  // A word that lands on the boundary cycle waits one slot: a Sync goes first
  assign load_sym    = buf_valid ? encode(WIDTH_SELECT_I, buf_word, 1'b0) : sync_sym;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_ref_q <= 1'b0;
    end else begin
      tx_ref_q <= TX_REF_CLK_I;
    end
  end

  // Byte counter and byte clock; the clock falls as the next byte starts
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_cnt        <= 4'h0;
      TX_BYTE_CLK_O <= 1'b0;
    end else if (tx_bit_en) begin
      tx_cnt        <= next_tx_cnt;
      TX_BYTE_CLK_O <= next_tx_cnt >= (nb >> 1);
    end
  end

  // Shifter loads at the boundary and shifts out MSB first
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_sh <= SBL_TX_SH_RST;
    end else if (tx_bit_en) begin
      tx_sh <= tx_bnd ? load_sym : {tx_sh[10:0], 1'b0};
    end
  end

  // Line output: transition on one, or plain level in the NRZ test mode
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SERIAL_OUT_O   <= 1'b0;
      SERIAL_OUT_N_O <= 1'b1;
    end else if (tx_bit_en) begin
      if (TEST_LEVEL_SELECT_I == SBL_TLS_NRZ) begin
        SERIAL_OUT_O   <= tx_sh[11];
        SERIAL_OUT_N_O <= ~tx_sh[11];
      end else begin
        SERIAL_OUT_O   <= SERIAL_OUT_O ^ tx_sh[11];
        SERIAL_OUT_N_O <= ~(SERIAL_OUT_O ^ tx_sh[11]);
      end
    end
  end

  // ==========================================================================
  // Receive: test detection, bit pacing and alignment
  // ==========================================================================
  logic [5:0]  neg_run;
  logic        xtal_q;
  logic        rx_bit_en;
  logic        line_q;
  logic        rx_bit;
  logic [11:0] rx_hist;
  logic [11:0] next_hist;
  sbl_dec_s    dec;
  logic        sync_hit;
  logic        rx_bnd;
  logic [3:0]  rx_cnt;
  logic [4:0]  rclk_cnt;
  logic [4:0]  next_rclk;
  logic        rclk_pend;
  logic        rclk_start;

  // A grounded negative input stays low far longer than any legal run
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      neg_run        <= 6'h00;
      RX_TEST_MODE_O <= 1'b0;
    end else begin
      if (SERIAL_IN_NEG_I) neg_run <= 6'h00;
      else if (neg_run != 6'(RX_TEST_RUN)) neg_run <= neg_run + 6'h01;
      RX_TEST_MODE_O <= !SERIAL_IN_NEG_I && (neg_run == 6'(RX_TEST_RUN));
    end
  end

  assign rx_bit_en = RX_TEST_MODE_O ? (CRYSTAL_IN_I & ~xtal_q) : 1'b1;
  assign rx_bit    = SERIAL_IN_POS_I ^ line_q;
  assign next_hist = {rx_hist[10:0], rx_bit};
  assign dec       = decode(WIDTH_SELECT_I, next_hist);
  // Sync forces a boundary; the partial word before it is simply dropped
  assign sync_hit  = rx_bit_en && (dec.kind == SBL_SYM_SYNC);
  assign rx_bnd    = rx_bit_en && ((rx_cnt == nb - 4'h1) || sync_hit);

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      xtal_q  <= 1'b0;
      line_q  <= 1'b0;
      rx_hist <= 12'h000;
      rx_cnt  <= 4'h0;
    end else begin
      xtal_q <= CRYSTAL_IN_I;
      if (rx_bit_en) begin
        line_q  <= SERIAL_IN_POS_I;
        rx_hist <= next_hist;
        rx_cnt  <= rx_bnd ? 4'h0 : rx_cnt + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Receive: output latches
  // ==========================================================================
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      RX_DATA_O            <= 10'h000;
      RX_CMD_O             <= 4'h0;
      DATA_OUT_STROBE_O    <= 1'b0;
      COMMAND_OUT_STROBE_O <= 1'b0;
      VIOLATION_O          <= 1'b0;
    end else begin
      DATA_OUT_STROBE_O    <= 1'b0;
      COMMAND_OUT_STROBE_O <= 1'b0;
      if (rx_bnd) begin
        unique case (dec.kind)
          SBL_SYM_SYNC: begin
            RX_CMD_O             <= 4'h0;
            COMMAND_OUT_STROBE_O <= 1'b1;
            VIOLATION_O          <= 1'b0;
          end
          SBL_SYM_CMD: begin
            RX_CMD_O             <= dec.val[3:0];
            COMMAND_OUT_STROBE_O <= 1'b1;
            VIOLATION_O          <= 1'b0;
          end
          SBL_SYM_DATA: begin
            RX_DATA_O         <= dec.val;
            DATA_OUT_STROBE_O <= 1'b1;
            VIOLATION_O       <= 1'b0;
          end
          SBL_SYM_BAD: begin
            VIOLATION_O <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Receive: byte clock with pulse stretching
  // ==========================================================================
  // A boundary that comes early after realignment is held off, trading
  // one late edge for a guarantee that no byte clock period is shorter than a byte
  assign rclk_start = (rx_bnd || rclk_pend) && (rclk_cnt >= {1'b0, nb - 4'h1});
  assign next_rclk  = rclk_start ? 5'h00 : (rclk_cnt == SBL_RCLK_SAT) ? rclk_cnt : rclk_cnt + 5'h01;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rclk_cnt      <= SBL_RCLK_SAT;
      rclk_pend     <= 1'b0;
      RX_BYTE_CLK_O <= 1'b0;
    end else if (rx_bit_en) begin
      rclk_cnt      <= next_rclk;
      rclk_pend     <= !rclk_start && (rclk_pend || rx_bnd);
      RX_BYTE_CLK_O <= next_rclk < {2'b00, nb[3:1]};
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_tx_idle_slot;
    tx_bnd && !buf_valid;
  endsequence

  sequence s_rx_sync_slot;
    rx_bnd && (dec.kind == SBL_SYM_SYNC);
  endsequence

  a_idle_sync_fill: assert property (s_tx_idle_slot |=> tx_sh == $past(sync_sym))
    else $error("idle slot did not load Sync");
  a_word_load_edge: assert property (tx_bnd && buf_valid |-> TX_BYTE_CLK_O ##1 !TX_BYTE_CLK_O
                                     && tx_sh == $past(encode(WIDTH_SELECT_I, buf_word, 1'b0)))
    else $error("word not loaded at byte clock fall");
  a_strobe_ack_pulse: assert property (push && INPUT_READY_O |=> ACK_O ##1 !ACK_O)
    else $error("accepted strobe not acknowledged once");
  a_nrzi_one_flip: assert property (tx_bit_en && TEST_LEVEL_SELECT_I != SBL_TLS_NRZ && tx_sh[11]
                                    |=> SERIAL_OUT_O != $past(SERIAL_OUT_O))
    else $error("one bit without transition");
  a_nrzi_zero_hold: assert property (tx_bit_en && TEST_LEVEL_SELECT_I != SBL_TLS_NRZ && !tx_sh[11]
                                     |=> $stable(SERIAL_OUT_O))
    else $error("zero bit with transition");
  a_nrz_plain_level: assert property (tx_bit_en && TEST_LEVEL_SELECT_I == SBL_TLS_NRZ
                                      |=> SERIAL_OUT_O == $past(tx_sh[11]) && SERIAL_OUT_N_O != SERIAL_OUT_O)
    else $error("NRZ output does not follow shifter");
  a_bypass_bit_hold: assert property (TEST_LEVEL_SELECT_I == SBL_TLS_BYP && !(TX_REF_CLK_I && !tx_ref_q)
                                      |=> $stable(SERIAL_OUT_O) && $stable(tx_cnt))
    else $error("bit advanced without reference edge");
  a_sync_cmd_clear: assert property (s_rx_sync_slot |=> COMMAND_OUT_STROBE_O && RX_CMD_O == 4'h0
                                     && !DATA_OUT_STROBE_O && $stable(RX_DATA_O))
    else $error("Sync did not clear commands");
  a_bclk_no_runt: assert property ($rose(RX_BYTE_CLK_O) |-> $past(rclk_cnt) >= {1'b0, nb - 4'h1})
    else $error("receive byte clock pulse too short");
  a_rx_xtal_pacing: assert property (RX_TEST_MODE_O && !(CRYSTAL_IN_I && !xtal_q) |=> $stable(rx_hist))
    else $error("receive bit taken without crystal edge");
  a_bad_sym_flag: assert property (rx_bnd && dec.kind == SBL_SYM_BAD
                                   |=> VIOLATION_O && !DATA_OUT_STROBE_O && !COMMAND_OUT_STROBE_O)
    else $error("unknown symbol not flagged");
  a_sync_realign: assert property (sync_hit |=> rx_cnt == 4'h0)
    else $error("Sync did not realign byte counter");

endmodule

`default_nettype wire

// ===== design/sbl_pair_buf.sv
// Small valid/ready buffer between the host strobe and the encoder.
// Assumes one clock and an active-low asynchronous reset.
`default_nettype none

module sbl_pair_buf #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Filling side
  input  wire logic             s_valid_i,
  input  wire logic [WIDTH-1:0] s_data_i,
  output logic                  s_ready_o,
  // Draining side
  output logic                  m_valid_o,
  output logic [WIDTH-1:0]      m_data_o,
  input  wire logic             m_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Occupancy
  // ==========================================================================
  assign push       = s_valid_i & s_ready_o;
  assign pop        = m_valid_o & m_ready_i;
  assign next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
  assign m_data_o   = mem[rd_ptr];

  // Flags are registered so that ready and valid never ripple through
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count     <= '0;
      s_ready_o <= 1'b1;
      m_valid_o <= 1'b0;
    end else begin
      count     <= next_count;
      s_ready_o <= next_count != (AW + 1)'(DEPTH);
      m_valid_o <= next_count != '0;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  // Storage has no reset; valid guards every read
  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr] <= s_data_i;
  end

endmodule

`default_nettype wire

// ===== shared/sbl_pkg.sv
// Constants, symbol tables and carrier types for the serial byte link codec.
// Assumes the width and test selects are static while the link runs.
`default_nettype none

package sbl_pkg;

  // ==========================================================================
  // Mode selects
  // ==========================================================================
  localparam logic [1:0] SBL_W8       = 2'h0;  // 8 data, 4 command
  localparam logic [1:0] SBL_W9       = 2'h1;  // 9 data, 3 command
  localparam logic [1:0] SBL_W10      = 2'h2;  // 10 data, 2 command
  localparam logic [1:0] SBL_TLS_NORM = 2'h0;  // Select tied low
  localparam logic [1:0] SBL_TLS_BYP  = 2'h1;  // Select open or mid-supply
  localparam logic [1:0] SBL_TLS_NRZ  = 2'h3;  // Select tied high

  // ==========================================================================
  // Symbol lengths, counts and reset values
  // ==========================================================================
  localparam logic [3:0]  SBL_NB8         = 4'hA;
  localparam logic [3:0]  SBL_NB9         = 4'hB;
  localparam logic [3:0]  SBL_NB10        = 4'hC;
  localparam int          SBL_RX_TEST_RUN = 32;      // Quiet negative-input cycles
  localparam logic [4:0]  SBL_RCLK_SAT    = 5'h1F;
  localparam logic [11:0] SBL_TX_SH_RST   = 12'hC44; // 8-bit Sync, left-justified

  // ==========================================================================
  // Symbol tables (index 0 of each command table is the Sync symbol)
  // ==========================================================================
  localparam logic [4:0] SBL_T45 [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                          5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [5:0] SBL_T56 [32] = '{6'h36, 6'h11, 6'h24, 6'h25, 6'h12, 6'h13, 6'h16, 6'h17,
                                          6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
                                          6'h3E, 6'h19, 6'h29, 6'h2D, 6'h1A, 6'h1B, 6'h1E, 6'h1F,
                                          6'h2A, 6'h2B, 6'h2E, 6'h2F, 6'h3A, 6'h3B, 6'h3C, 6'h3D};
  localparam logic [9:0] SBL_CMD8 [16] = '{10'h311, 10'h3FF, 10'h1AD, 10'h1B9, 10'h3E4, 10'h1A7,
                                           10'h327, 10'h339, 10'h084, 10'h09F, 10'h080, 10'h0E7,
                                           10'h0F9, 10'h004, 10'h01F, 10'h000};
  localparam logic [10:0] SBL_CMD9 [8] = '{11'h311, 11'h7FF, 11'h3AD, 11'h3B9, 11'h7E4, 11'h3A7,
                                           11'h727, 11'h739};
  localparam logic [11:0] SBL_CMD10 [4] = '{12'h623, 12'hFFF, 12'h75D, 12'h779};

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [3:0] cmd;
    logic [9:0] data;
  } sbl_word_s;

  typedef enum logic [1:0] {SBL_SYM_BAD, SBL_SYM_SYNC, SBL_SYM_CMD, SBL_SYM_DATA} sbl_kind_e;

  typedef struct packed {
    sbl_kind_e  kind;
    logic [9:0] val;
  } sbl_dec_s;

endpackage

`default_nettype wire

// ===== testbench/sbl_far_end.sv
// Far end of the serial link: loops the transmit line back into the receiver.
// Assumes the line is driven without a break, so no released level is modelled.
`default_nettype none
module sbl_far_end (
  // Transmit line
  input  wire logic line_i,
  // Receive pair
  output logic      pos_o,
  output logic      neg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Loopback
  // ====
  // Negative leg keeps toggling, so receive test mode never trips
  assign pos_o = line_i;
  assign neg_o = ~line_i;
endmodule
`default_nettype wire

// ===== testbench/serial_byte_link_codec_bench.sv
// Bench for the byte link codec: host tasks send words, the far end loops the line.
// Assumes the package and design are compiled first; width and test mode change only in reset.
`default_nettype none
module serial_byte_link_codec_bench import sbl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_n = 0, stb = 0, rfc = 0, ack, rdy, so, son, pos, neg, dst, cst, bc, rbc, vlt, rtm;
  logic [1:0]  wsel = SBL_W8, test_level_select = SBL_TLS_NORM;
  logic [11:0] ln = 12'h000, sym;
  logic [9:0]  rd;
  logic [3:0]  rc;
  int          mismatches = 0, checks_done = 0, n, i, rbh;
  // ====
  // Clock, design, far end
  // ====
  initial forever #50 clk = ~clk;
  // Reference toggles each falling edge in bypass, so one bit takes two clocks
  always @(negedge clk) rfc <= (test_level_select == SBL_TLS_BYP) ? ~rfc : 1'b0;
  sbl_codec u_dut (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .WIDTH_SELECT_I(wsel), .TEST_LEVEL_SELECT_I(test_level_select),
    .TX_LINES_I(ln), .INPUT_STROBE_I(stb), .TX_REF_CLK_I(rfc), .ACK_O(ack), .INPUT_READY_O(rdy),
    .SERIAL_OUT_O(so), .SERIAL_OUT_N_O(son), .TX_BYTE_CLK_O(bc), .SERIAL_IN_POS_I(pos), .SERIAL_IN_NEG_I(neg),
    .CRYSTAL_IN_I(1'b0), .RX_DATA_O(rd), .RX_CMD_O(rc), .DATA_OUT_STROBE_O(dst), .COMMAND_OUT_STROBE_O(cst),
    .VIOLATION_O(vlt), .RX_BYTE_CLK_O(rbc), .RX_TEST_MODE_O(rtm));
  sbl_far_end u_far (.line_i(so), .pos_o(pos), .neg_o(neg));
  // ====
  // Tasks
  // ====
  task automatic close_out();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Case inequality, so an unknown never passes
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // A used-up wait ends the run instead of hanging
  task automatic tmo(input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("BAD %0t wait ran out", $time);
      close_out();
    end
  endtask
  // Strobe held until acknowledged, then low for a cycle
  task automatic send(input logic [11:0] w);
    ln = w;
    stb = 1'b1;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(negedge clk);
    tmo(20);
    stb = 1'b0;
    @(negedge clk);
  endtask
  // Finds the next fall of the byte clock
  task automatic align();
    for (n = 0; n < 40 && bc !== 1'b1; n++) @(negedge clk);
    tmo(40);
    for (n = 0; n < 40 && bc !== 1'b0; n++) @(negedge clk);
    tmo(40);
  endtask
  // Undoes the line coding of the nb-bit symbol after a boundary, st clocks per bit
  task automatic grab(input logic [11:0] exp, input int nb, input int st);
    logic prev;
    align();
    prev = so;
    sym = 12'h000;
    for (i = 0; i < nb; i++) begin
      repeat (st) @(negedge clk);
      sym = {sym[10:0], (test_level_select == SBL_TLS_NRZ) ? so : so ^ prev};
      prev = so;
    end
    chk(sym, exp);
    chk({11'h0, son}, {11'h0, ~so});
  endtask
  // Next received word, idle Sync skipped
  task automatic rx_next();
    for (n = 0; n < 200; n++) begin
      @(negedge clk);
      if (dst === 1'b1 || (cst === 1'b1 && rc !== 4'h0)) break;
    end
    tmo(200);
  endtask
  // Mid-run reset that switches width and test mode while the link is held
  task automatic restart(input logic [1:0] w, input logic [1:0] t);
    rst_n = 1'b0;
    wsel = w;
    test_level_select = t;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (40) @(negedge clk);
  endtask
  // ====
  // Scenarios
  // ====
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (40) @(negedge clk);
    grab(12'h311, 10, 1);
    // Locked receiver: byte clock high for half of every ten bits
    rbh = 0;
    repeat (10) begin
      @(negedge clk);
      rbh += rbc;
    end
    chk(12'(rbh), 12'h005);
    align();
    send(12'h000);
    grab(12'h3DE, 10, 1);
    rx_next();
    chk({2'h0, rd}, 12'h000);
    align();
    send(12'h5FF);
    grab(12'h1A7, 10, 1);
    rx_next();
    chk({8'h0, rc}, 12'h005);
    // Two words inside one byte fill the buffer
    align();
    send(12'h0A5);
    send(12'h03C);
    chk({11'h0, rdy}, 12'h000);
    rx_next();
    chk({2'h0, rd}, 12'h0A5);
    rx_next();
    chk({2'h0, rd}, 12'h03C);
    for (n = 0; n < 40 && !(cst === 1'b1 && rc === 4'h0); n++) @(negedge clk);
    tmo(40);
    chk({2'h0, rd}, 12'h03C);
    chk({11'h0, rdy}, 12'h001);
    for (int c = 1; c < 16; c++) begin
      send({c[3:0], 8'h00});
      rx_next();
      chk({8'h0, rc}, {8'h0, c[3:0]});
    end
    for (int d = 0; d < 256; d += 17) begin
      send({4'h0, d[7:0]});
      rx_next();
      chk({2'h0, rd}, {4'h0, d[7:0]});
    end
    chk({10'h0, vlt, rtm}, 12'h000);
    // Ten-bit width: 5B/6B both halves, bit nine leads the lower group
    restart(SBL_W10, SBL_TLS_NORM);
    grab(12'h623, 12, 1);
    align();
    send(12'h2A5);
    grab(12'hDDB, 12, 1);
    rx_next();
    chk({2'h0, rd}, 12'h2A5);
    send(12'h800);
    rx_next();
    chk({8'h0, rc}, 12'h002);
    // Nine-bit width with plain NRZ output; the looped receiver is not judged here
    restart(SBL_W9, SBL_TLS_NRZ);
    grab(12'h311, 11, 1);
    align();
    send(12'h1A5);
    grab(12'h5CB, 11, 1);
    // Bypass: one bit per reference edge, two clocks apiece
    restart(SBL_W8, SBL_TLS_BYP);
    grab(12'h311, 10, 2);
    close_out();
  end
endmodule
`default_nettype wire
